// >>> bench/tb_top.sv
// Self-checking testbench for the pump divider register bank
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk         = 1'b0;
    logic        rst_b           = 1'b0;
    logic [7:0]  paddr           = 8'h00;
    logic        psel            = 1'b0;
    logic        penable         = 1'b0;
    logic        pwrite          = 1'b0;
    logic [31:0] pwdata          = 32'h0;
    logic [3:0]  pstrb           = 4'hf;
    logic [11:0] brightness      = 12'hfff;
    logic [7:0]  fault_in        = 8'h00;
    logic        nv_reload       = 1'b0;
    logic        factory_csum_ok = 1'b0;
    logic [7:0]  nv_cfg_default  = 8'h00;
    logic [15:0] user_csum       = 16'h0;
    logic        nv_write_done   = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        nv_write_start;
    logic [1:0]  pump_div_sel;
    logic        pump_clk_en;
    logic [31:0] rd;
    logic        er;
    int          fails   = 0;
    int          n_tests = 0;

    pdc_regs #(.BRIGHT_W(12)) dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .brightness(brightness), .fault_in(fault_in), .nv_reload(nv_reload),
        .factory_csum_ok(factory_csum_ok), .nv_cfg_default(nv_cfg_default),
        .user_csum(user_csum), .nv_write_done(nv_write_done),
        .nv_write_start(nv_write_start), .pump_div_sel(pump_div_sel),
        .pump_clk_en(pump_clk_en)
    );

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic results();
        if (fails == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; read data and error are taken at the completing edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) chk("pready", 32'h1, 32'h0);
    endtask : apb

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
        chk({what, "_err"}, 32'h0, 32'(er));
    endtask : rdchk

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : settle

    task automatic pulse_reload();
        @(posedge sys_clk);
        nv_reload <= 1'b1;
        @(posedge sys_clk);
        nv_reload <= 1'b0;
    endtask : pulse_reload

    task automatic t_reset();
        rdchk("fault_rst", 8'h38, 32'h0);
        rdchk("cfg_rst", 8'h2c, 32'h0);
        rdchk("csum_lo_rst", 8'h30, 32'h0);
        chk("div_rst", 32'h0, 32'(pump_div_sel));
    endtask : t_reset

    // Exact threshold codes and one below each: 0=1/2, 1=1/4, 2=1/8
    task automatic t_auto();
        logic [11:0] lv [5] = '{12'hc00, 12'hbff, 12'h800, 12'h7ff, 12'hfff};
        logic [1:0]  ex [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0};
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            brightness <= lv[i];
            settle(1);
            chk("div_auto", 32'(ex[i]), 32'(pump_div_sel));
        end
    endtask : t_auto

    // Brightness chosen so that auto mode would give a different answer
    task automatic t_fixed();
        for (int d = 0; d < 4; d++) begin
            @(posedge sys_clk);
            brightness <= (d == 0) ? 12'h000 : 12'hfff;
            apb(1'b1, 8'h2c, 32'h0f4 | 32'(d));
            settle(1);
            chk("div_fixed", 32'((d == 0) ? 0 : (d == 1) ? 1 : 2), 32'(pump_div_sel));
            rdchk("cfg_rd", 8'h2c, 32'(4 + d));
        end
        pstrb <= 4'he;
        apb(1'b1, 8'h2c, 32'h0);
        pstrb <= 4'hf;
        rdchk("cfg_strb", 8'h2c, 32'h07);
    endtask : t_fixed

    task automatic t_trans();
        for (int c = 0; c < 8; c++) begin
            for (int h = 0; h < 2; h++) begin
                @(posedge sys_clk);
                brightness <= (h == 1) ? 12'h800 : 12'h7ff;
                if (h == 0) apb(1'b1, 8'h2c, 32'(8 + c));
                settle(1);
                chk("div_tran", 32'(c % 2 + 1 - h), 32'(pump_div_sel));
            end
        end
    endtask : t_trans

    task automatic t_fault();
        apb(1'b1, 8'h38, 32'hff);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            fault_in <= 8'h01 << i;
            settle(1);
            rdchk("fault_bit", 8'h38, 32'h1 << i);
        end
        @(posedge sys_clk);
        fault_in <= 8'h00;
        settle(1);
        rdchk("fault_clr", 8'h38, 32'h0);
    endtask : t_fault

    task automatic t_csum();
        @(posedge sys_clk);
        user_csum      <= 16'hbeef;
        nv_cfg_default <= 8'hf6;
        settle(2);
        rdchk("csum_noload", 8'h30, 32'h0);
        pulse_reload();
        rdchk("csum_lo", 8'h30, 32'hef);
        rdchk("csum_hi", 8'h34, 32'hbe);
        rdchk("cfg_bad_fact", 8'h2c, 32'h0f);
        @(posedge sys_clk);
        factory_csum_ok <= 1'b1;
        pulse_reload();
        rdchk("cfg_nv_load", 8'h2c, 32'h06);
    endtask : t_csum

    task automatic t_nv();
        int seen;
        seen = 0;
        apb(1'b1, 8'h40, 32'h90);
        repeat (3) begin
            @(negedge sys_clk);
            if (nv_write_start === 1'b1) seen++;
        end
        chk("nv_start", 32'h1, 32'(seen));
        @(posedge sys_clk);
        user_csum <= 16'h1234;
        rdchk("nv_busy", 8'h40, 32'h90);
        @(posedge sys_clk);
        nv_write_done <= 1'b1;
        @(posedge sys_clk);
        nv_write_done <= 1'b0;
        settle(1);
        rdchk("csum_after_wr", 8'h30, 32'hef);
        rdchk("nv_done", 8'h40, 32'h04);
        rdchk("nv_done_clr", 8'h40, 32'h0);
        pulse_reload();
        rdchk("csum_refresh", 8'h34, 32'h12);
    endtask : t_nv

    // Pump enable rate follows the selected ratio
    task automatic t_tick(input logic [31:0] cfg, input int exp);
        int cnt;
        cnt = 0;
        apb(1'b1, 8'h2c, cfg);
        settle(2);
        repeat (32) begin
            @(negedge sys_clk);
            if (pump_clk_en === 1'b1) cnt++;
        end
        chk("pump_ticks", 32'(exp), 32'(cnt));
    endtask : t_tick

    task automatic t_bad();
        apb(1'b0, 8'h3c, 32'h0);
        chk("unmapped_err", 32'h1, 32'(er));
        chk("unmapped_data", 32'h0, rd);
    endtask : t_bad

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        settle(1);
        t_reset();
        t_auto();
        t_fixed();
        t_trans();
        t_fault();
        t_csum();
        t_nv();
        t_tick(32'h06, 4);
        t_tick(32'h05, 8);
        t_bad();
        results();
    end

    // Whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        results();
    end

endmodule : tb_top

`default_nettype wire

// >>> logic/pdc_pkg.sv
// Package: register map, field layout and constants of the pump divider bank
`default_nettype none

package pdc_pkg;

    // Register indices; the APB byte address is four times the index
    localparam logic [5:0] IDX_PUMP_CFG = 6'h0b;
    localparam logic [5:0] IDX_CSUM_LO  = 6'h0c;
    localparam logic [5:0] IDX_CSUM_HI  = 6'h0d;
    localparam logic [5:0] IDX_FAULT    = 6'h0e;
    localparam logic [5:0] IDX_NV_CTRL  = 6'h10;

    // Reset values (factory defaults before the nonvolatile reload)
    localparam logic [3:0]  PUMP_CFG_RST = 4'h0;
    localparam logic [15:0] CSUM_RST     = 16'h0000;
    localparam logic [7:0]  FAULT_RST    = 8'h00;
    localparam logic [4:0]  NV_CMD_RST   = 5'h00;

    // Pump divider config fields
    localparam int unsigned CFG_W       = 4;
    localparam int unsigned CFG_TRAN    = 3;
    localparam int unsigned CFG_FSEL    = 2;
    localparam int unsigned CFG_DIV_HI  = 1;
    localparam int unsigned CFG_DIV_LO  = 0;

    // Nonvolatile control fields
    localparam int unsigned NV_CMD_LSB  = 3;
    localparam int unsigned NV_CMD_W    = 5;
    localparam int unsigned NV_DONE_BIT = 2;
    localparam logic [4:0]  NV_CMD_PROGRAM = 5'h12;

    // Fault status bit positions
    localparam int unsigned FLT_BOOST_ILIM = 7;
    localparam int unsigned FLT_VOUT_OV    = 6;
    localparam int unsigned FLT_MID_OV     = 5;
    localparam int unsigned FLT_MID_UV     = 4;
    localparam int unsigned FLT_DISC_OC    = 3;
    localparam int unsigned FLT_THERMAL    = 2;
    localparam int unsigned FLT_SS_TIMEOUT = 1;
    localparam int unsigned FLT_STR_SHORT  = 0;
    localparam int unsigned FLT_W          = 8;

    // Brightness thresholds in percent of full scale
    localparam int unsigned BRIGHT_W_DEF = 12;
    localparam int unsigned PCT_HIGH     = 75;
    localparam int unsigned PCT_LOW      = 50;

    // Pump clock divider selection and last count of each ratio
    typedef enum logic [1:0] {
        PDC_DIV2,
        PDC_DIV4,
        PDC_DIV8
    } pdc_div_t;

    localparam logic [2:0] DIV2_LAST = 3'h1;
    localparam logic [2:0] DIV4_LAST = 3'h3;
    localparam logic [2:0] DIV8_LAST = 3'h7;

    typedef enum logic {
        PDC_NV_IDLE,
        PDC_NV_BUSY
    } pdc_nv_state_t;

endpackage : pdc_pkg

`default_nettype wire

// >>> logic/pdc_pump_tick.sv
// Charge pump clock enable: one-cycle pulse every 2, 4 or 8 system clocks
`default_nettype none

module pdc_pump_tick (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire pdc_pkg::pdc_div_t div_sel,
    output var  logic             tick
);

    logic [2:0] count_q;
    logic [2:0] count_d;
    logic [2:0] last_w;
    logic       wrap_w;

    assign last_w = (div_sel == pdc_pkg::PDC_DIV2) ? pdc_pkg::DIV2_LAST :
                    (div_sel == pdc_pkg::PDC_DIV4) ? pdc_pkg::DIV4_LAST :
                                                      pdc_pkg::DIV8_LAST;

    // A ratio change mid-count must not run past the new last count
    assign wrap_w  = (count_q >= last_w);
    assign count_d = wrap_w ? 3'h0 : count_q + 3'h1;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= 3'h0;
            tick    <= 1'b0;
        end else begin
            count_q <= count_d;
            tick    <= wrap_w;
        end
    end

endmodule : pdc_pump_tick

`default_nettype wire

// >>> logic/pdc_regs.sv
// Top: APB register bank for pump divider select, checksum and fault status
// Summary of operation
// - Auto mode steps divider at 75% and 50%
// - Fixed select maps field to 1/2,1/4,1/8
// - Transition mode ignores fixed select, 50% only
// - Bit0 clear: 1/2 at/above 50%, else 1/4
// - Bit0 set: 1/4 at/above 50%, else 1/8
// - Read-only 16-bit checksum, low then high byte
// - Nonvolatile values load when factory checksum valid
// - Checksum refreshes only on enable or power cycle
// - Bit 7 flags boost secondary current limit
// - Bit 6 flags output over-voltage
// - Bits 5,4 flag mid node over/under-voltage
// - Bit 3 flags disconnect over-current or short
// - Bit 2 flags thermal shutdown
// - Bit 1 flags soft-start timeout
// - Bit 0 flags shorted LED string
// - Reset from factory defaults; fault status 0x00
// - Command 10010 programs; device clears, flags done
//
// The APB slave port is this design's own decision.
`default_nettype none

module pdc_regs #(
    parameter int unsigned BRIGHT_W = pdc_pkg::BRIGHT_W_DEF
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    input  wire logic [7:0]          paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output var  logic [31:0]         prdata,
    output var  logic                pready,
    output var  logic                pslverr,
    input  wire logic [BRIGHT_W-1:0] brightness,
    input  wire logic [7:0]          fault_in,
    input  wire logic                nv_reload,
    input  wire logic                factory_csum_ok,
    input  wire logic [7:0]          nv_cfg_default,
    input  wire logic [15:0]         user_csum,
    input  wire logic                nv_write_done,
    output var  logic                nv_write_start,
    output var  logic [1:0]          pump_div_sel,
    output var  logic                pump_clk_en
);

    localparam logic [BRIGHT_W-1:0] LVL_HIGH =
        BRIGHT_W'(((2 ** BRIGHT_W) * pdc_pkg::PCT_HIGH) / 100);
    localparam logic [BRIGHT_W-1:0] LVL_LOW =
        BRIGHT_W'(((2 ** BRIGHT_W) * pdc_pkg::PCT_LOW) / 100);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [pdc_pkg::CFG_W-1:0]    cfg_q;
    logic [pdc_pkg::CFG_W-1:0]    cfg_d;
    logic [15:0]                  csum_q;
    logic [15:0]                  csum_d;
    logic [pdc_pkg::FLT_W-1:0]    fault_q;
    pdc_pkg::pdc_div_t            div_q;
    pdc_pkg::pdc_div_t            div_d;
    pdc_pkg::pdc_nv_state_t       nv_state_q;
    pdc_pkg::pdc_nv_state_t       nv_state_d;
    logic [pdc_pkg::NV_CMD_W-1:0] nv_cmd_q;
    logic [pdc_pkg::NV_CMD_W-1:0] nv_cmd_d;
    logic                         nv_done_q;
    logic                         nv_done_d;
    logic                         nv_start_d;
    logic                         pready_d;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic       access_w;
    logic       fire_w;
    logic       wr_fire_w;
    logic       rd_fire_w;
    logic [5:0] idx_w;
    logic       aligned_w;
    logic       hit_cfg_w;
    logic       hit_lo_w;
    logic       hit_hi_w;
    logic       hit_flt_w;
    logic       hit_nv_w;
    logic       mapped_w;
    logic [7:0] rd_data_w;

    assign access_w  = psel && penable;
    // Zero-wait answers would need combinational read data, so one wait
    assign fire_w    = access_w && pready;
    assign wr_fire_w = fire_w && pwrite && pstrb[0];
    assign rd_fire_w = fire_w && !pwrite;
    assign idx_w     = paddr[7:2];
    assign aligned_w = (paddr[1:0] == 2'h0);

    assign hit_cfg_w = aligned_w && (idx_w == pdc_pkg::IDX_PUMP_CFG);
    assign hit_lo_w  = aligned_w && (idx_w == pdc_pkg::IDX_CSUM_LO);
    assign hit_hi_w  = aligned_w && (idx_w == pdc_pkg::IDX_CSUM_HI);
    assign hit_flt_w = aligned_w && (idx_w == pdc_pkg::IDX_FAULT);
    assign hit_nv_w  = aligned_w && (idx_w == pdc_pkg::IDX_NV_CTRL);
    assign mapped_w  = hit_cfg_w || hit_lo_w || hit_hi_w || hit_flt_w || hit_nv_w;

    assign rd_data_w =
        hit_cfg_w ? {4'h0, cfg_q} :
        hit_lo_w  ? csum_q[7:0] :
        hit_hi_w  ? csum_q[15:8] :
        hit_flt_w ? fault_q :
        hit_nv_w  ? {nv_cmd_q, nv_done_q, 2'h0} :
                    8'h00;

    assign pready_d = access_w && !pready;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready <= pready_d;
            if (pready_d) begin
                pslverr <= !mapped_w;
                prdata  <= {24'h00_0000, rd_data_w};
            end
        end
    end

    // ------------------------------------------------------------
    // Pump divider configuration
    // ------------------------------------------------------------
    // A reload stands for an enable toggle or power cycle, so with a valid
    // factory checksum it beats a register write landing in the same cycle
    assign cfg_d =
        (nv_reload && factory_csum_ok) ? nv_cfg_default[pdc_pkg::CFG_W-1:0] :
        (wr_fire_w && hit_cfg_w)       ? pwdata[pdc_pkg::CFG_W-1:0] :
                                         cfg_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= pdc_pkg::PUMP_CFG_RST;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // ------------------------------------------------------------
    // Divider selection from brightness
    // ------------------------------------------------------------
    logic              cfg_tran_w;
    logic              cfg_fsel_w;
    logic              ge_high_w;
    logic              ge_low_w;
    pdc_pkg::pdc_div_t auto_div_w;
    pdc_pkg::pdc_div_t fixed_div_w;
    pdc_pkg::pdc_div_t tran_div_w;

    assign cfg_tran_w = cfg_q[pdc_pkg::CFG_TRAN];
    assign cfg_fsel_w = cfg_q[pdc_pkg::CFG_FSEL];

    // Plain compares each cycle; a level dithering on a threshold
    // will toggle the ratio
    assign ge_high_w = (brightness >= LVL_HIGH);
    assign ge_low_w  = (brightness >= LVL_LOW);

    assign auto_div_w = ge_high_w ? pdc_pkg::PDC_DIV2 :
                        ge_low_w  ? pdc_pkg::PDC_DIV4 :
                                    pdc_pkg::PDC_DIV8;

    assign fixed_div_w = cfg_q[pdc_pkg::CFG_DIV_HI] ? pdc_pkg::PDC_DIV8 :
                         cfg_q[pdc_pkg::CFG_DIV_LO] ? pdc_pkg::PDC_DIV4 :
                                                      pdc_pkg::PDC_DIV2;

    assign tran_div_w =
        cfg_q[pdc_pkg::CFG_DIV_LO] ?
            (ge_low_w ? pdc_pkg::PDC_DIV4 : pdc_pkg::PDC_DIV8) :
            (ge_low_w ? pdc_pkg::PDC_DIV2 : pdc_pkg::PDC_DIV4);

    assign div_d = cfg_tran_w ? tran_div_w :
                   cfg_fsel_w ? fixed_div_w :
                                auto_div_w;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= pdc_pkg::PDC_DIV2;
        end else begin
            div_q <= div_d;
        end
    end

    assign pump_div_sel = div_q;

    pdc_pump_tick u_tick (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .div_sel (div_q),
        .tick    (pump_clk_en)
    );

    // ------------------------------------------------------------
    // Checksum bytes
    // ------------------------------------------------------------
    // A finished programming cycle does not touch these
    assign csum_d = nv_reload ? user_csum : csum_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            csum_q <= pdc_pkg::CSUM_RST;
        end else begin
            csum_q <= csum_d;
        end
    end

    // ------------------------------------------------------------
    // Fault status, one live bit per condition
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < pdc_pkg::FLT_W; gi++) begin : g_fault
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    fault_q[gi] <= pdc_pkg::FAULT_RST[gi];
                end else begin
                    fault_q[gi] <= fault_in[gi];
                end
            end
        end
    endgenerate

    // Status bit n is fault_in bit n, so the port order sets the layout:

    // ------------------------------------------------------------
    // Nonvolatile programming command
    // ------------------------------------------------------------
    logic nv_cmd_wr_w;
    logic nv_go_w;
    logic nv_finish_w;
    logic nv_rd_clr_w;
    logic [pdc_pkg::NV_CMD_W-1:0] nv_wr_cmd_w;

    assign nv_wr_cmd_w = pwdata[pdc_pkg::NV_CMD_LSB +: pdc_pkg::NV_CMD_W];
    assign nv_cmd_wr_w = wr_fire_w && hit_nv_w;
    assign nv_go_w     = nv_cmd_wr_w && (nv_state_q == pdc_pkg::PDC_NV_IDLE) &&
                         (nv_wr_cmd_w == pdc_pkg::NV_CMD_PROGRAM);
    assign nv_finish_w = (nv_state_q == pdc_pkg::PDC_NV_BUSY) && nv_write_done;
    assign nv_rd_clr_w = rd_fire_w && hit_nv_w;

    always_comb begin
        nv_state_d = nv_state_q;
        nv_cmd_d   = nv_cmd_q;
        nv_start_d = 1'b0;
        case (nv_state_q)
            pdc_pkg::PDC_NV_IDLE: begin
                if (nv_cmd_wr_w) begin
                    nv_cmd_d = nv_wr_cmd_w;
                end
                if (nv_go_w) begin
                    nv_start_d = 1'b1;
                    nv_state_d = pdc_pkg::PDC_NV_BUSY;
                end
            end
            pdc_pkg::PDC_NV_BUSY: begin
                // Command stays readable and locked while programming runs
                if (nv_write_done) begin
                    nv_cmd_d   = pdc_pkg::NV_CMD_RST;
                    nv_state_d = pdc_pkg::PDC_NV_IDLE;
                end
            end
            default: begin
                nv_state_d = pdc_pkg::PDC_NV_IDLE;
                nv_cmd_d   = pdc_pkg::NV_CMD_RST;
            end
        endcase
    end

    // Set beats the clear-on-read in the same cycle
    assign nv_done_d = nv_finish_w ? 1'b1 :
                       nv_rd_clr_w ? 1'b0 :
                                     nv_done_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            nv_state_q     <= pdc_pkg::PDC_NV_IDLE;
            nv_cmd_q       <= pdc_pkg::NV_CMD_RST;
            nv_done_q      <= 1'b0;
            nv_write_start <= 1'b0;
        end else begin
            nv_state_q     <= nv_state_d;
            nv_cmd_q       <= nv_cmd_d;
            nv_done_q      <= nv_done_d;
            nv_write_start <= nv_start_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    auto_high_a:
    assert property ((!cfg_tran_w && !cfg_fsel_w && ge_high_w)
                     |=> (pump_div_sel == pdc_pkg::PDC_DIV2))
        else $error("auto mode above high threshold not at half");

    auto_low_a:
    assert property ((!cfg_tran_w && !cfg_fsel_w && !ge_low_w)
                     |=> (pump_div_sel == pdc_pkg::PDC_DIV8))
        else $error("auto mode below low threshold not at eighth");

    fixed_map_a:
    assert property ((!cfg_tran_w && cfg_fsel_w && cfg_q[1:0] == 2'h1)
                     |=> (pump_div_sel == pdc_pkg::PDC_DIV4))
        else $error("fixed field 01 did not give quarter");

    tran_half_a:
    assert property ((cfg_tran_w && !cfg_q[0] && ge_low_w)
                     |=> (pump_div_sel == pdc_pkg::PDC_DIV2))
        else $error("transition mode bit0 clear high not half");

    tran_eighth_a:
    assert property ((cfg_tran_w && cfg_q[0] && !ge_low_w)
                     |=> (pump_div_sel == pdc_pkg::PDC_DIV8))
        else $error("transition mode bit0 set low not eighth");

    csum_hold_a:
    assert property (!nv_reload |=> $stable(csum_q))
        else $error("checksum changed without reload");

    csum_read_a:
    assert property ((pready_d && !pwrite && hit_hi_w && !nv_reload)
                     |=> (prdata[7:0] == csum_q[15:8]))
        else $error("checksum high byte read mismatch");

    cfg_load_a:
    assert property ((nv_reload && factory_csum_ok)
                     |=> (cfg_q == $past(nv_cfg_default[3:0])))
        else $error("config not loaded from nonvolatile defaults");

    fault_follow_a:
    assert property ($stable(fault_in) |-> (fault_q == fault_in))
        else $error("fault status not following its inputs");

    nv_start_a:
    assert property (nv_go_w |=> nv_write_start ##1 !nv_write_start)
        else $error("program start not a single pulse");

    nv_done_a:
    assert property (nv_finish_w |=> (nv_done_q && nv_cmd_q == 5'h00))
        else $error("command not cleared or done not set");

    apb_wait_a:
    assert property ((access_w && !pready) |=> pready ##1 !pready)
        else $error("apb answer not after one wait cycle");

endmodule : pdc_regs

`default_nettype wire
